/* inc/agu_pkg.sv */
package agu_pkg;

  // ----------------------------------------------------------------
  // General register numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] reg_r2 = 4'h2;
  localparam logic [3:0] reg_r3 = 4'h3;
  localparam logic [3:0] reg_r4 = 4'h4;
  localparam logic [3:0] reg_r5 = 4'h5;
  localparam logic [3:0] reg_r6 = 4'h6;
  localparam logic [3:0] reg_r7 = 4'h7;
  localparam logic [3:0] reg_r8 = 4'h8;
  localparam logic [3:0] reg_r9 = 4'h9;

  // ----------------------------------------------------------------
  // Steps and field layout
  // ----------------------------------------------------------------
  localparam logic [15:0] xy_step_word = 16'h0002;
  localparam logic [31:0] single_step_word = 32'h0000_0002;
  localparam logic [31:0] single_step_long = 32'h0000_0004;
  localparam int unsigned end_field_lsb = 16;
  localparam int unsigned start_field_lsb = 0;
  localparam int unsigned field_w = 16;
  localparam logic [31:0] bounds_reset = 32'h0000_0000;

  // ----------------------------------------------------------------
  // Modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {xy_keep, xy_index, xy_inc} xy_mode_t;
  typedef enum logic [1:0] {s_keep, s_index, s_inc, s_dec} single_mode_t;

endpackage : agu_pkg

/* design/xy_pointer_update.sv */
module xy_pointer_update
  import agu_pkg::*;
(
  // Pointer in
  input wire logic [31:0] pointer,
  input wire xy_mode_t mode,
  input wire logic [15:0] index,
  // Circular bounds
  input wire logic circular,
  input wire logic [15:0] start_field,
  input wire logic [15:0] end_field,
  // Result
  output logic [31:0] updated,
  output logic wrapped
);

  wire logic [15:0] step;
  wire logic [15:0] sum;
  wire logic end_hit;

  assign step = (mode == xy_index) ? index : xy_step_word;
  // Lower halfword only; carry out of bit 15 is dropped
  assign sum = 16'(pointer[15:0] + step);
  // Exact match only; overshoot carries on linearly
  assign end_hit = (pointer[15:1] == end_field[15:1]);
  assign wrapped = circular && (mode != xy_keep) && end_hit;

  always_comb begin
    if (mode == xy_keep) begin
      updated = pointer;
    end else if (wrapped) begin
      updated = {pointer[31:16], start_field[15:1], pointer[0]};
    end else begin
      updated = {pointer[31:16], sum};
    end
  end

endmodule : xy_pointer_update

/* design/dsp_data_address_generator.sv */
// Operation
// - X pointer is R4 or R5, Y pointer is R6 or R7.
// - R8 indexes the X pointer, R9 indexes the Y pointer.
// - Dual modes: keep, add index, add two; X and Y independent.
// - X and Y word accesses issue together, pointer addresses only.
// - X/Y bus address uses pointer bits 15..1, bit 0 ignored.
// - X/Y bus ignores upper halfword; update writes lower halfword only.
// - Single pointer is one of R2..R5, indexed by R8.
// - Single modes: keep, add index, add two/four, pre-subtract two/four.
// - Pre-decrement subtracts first and drives the new address.
// - Dual and post-update single drive the old pointer, then write back.
// - Circular wrap only on dual moves; single moves update linearly.
// - X and Y circular enables; both set means only Y wraps.
// - Circular: old bits 15..1 equal end field load start, else add.
// - Wrap writes start into bits 15..1, keeps bit 0 and upper half.
// - Keep mode never wraps, even when the pointer equals the end.
// - Index-add wraps only on an exact end match.
// - Bounds register holds start and end fields, region up to 64 KB.
// - All address work and updates happen in the execute stage.
module dsp_data_address_generator
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Register file read values
  input wire logic [31:0] reg_r2,
  input wire logic [31:0] reg_r3,
  input wire logic [31:0] reg_r4,
  input wire logic [31:0] reg_r5,
  input wire logic [31:0] reg_r6,
  input wire logic [31:0] reg_r7,
  input wire logic [31:0] reg_r8,
  input wire logic [31:0] reg_r9,
  // Status register circular enables
  input wire logic x_circular_enable,
  input wire logic y_circular_enable,
  // Bounds register load
  input wire logic bounds_load,
  input wire logic [31:0] bounds_value,
  // Dual move request
  input wire logic x_word_move,
  input wire logic x_pointer_sel,
  input wire xy_mode_t x_mode,
  input wire logic y_word_move,
  input wire logic y_pointer_sel,
  input wire xy_mode_t y_mode,
  // Single move request
  input wire logic single_move,
  input wire logic single_long_move,
  input wire logic [1:0] single_pointer_sel,
  input wire single_mode_t single_mode,
  // X/Y buses
  output logic [15:0] x_address_bus,
  output logic x_access,
  output logic [15:0] y_address_bus,
  output logic y_access,
  // Main bus
  output logic [31:0] main_address_bus,
  output logic main_access,
  output logic main_long,
  // Write back
  output logic x_wb_valid,
  output logic [3:0] x_wb_reg,
  output logic [31:0] x_wb_value,
  output logic y_wb_valid,
  output logic [3:0] y_wb_reg,
  output logic [31:0] y_wb_value,
  output logic s_wb_valid,
  output logic [3:0] s_wb_reg,
  output logic [31:0] s_wb_value,
  // Status
  output logic [31:0] circular_bounds_register,
  output logic x_wrapped,
  output logic y_wrapped,
  output logic odd_operand
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [31:0] bounds_q, bounds_d;
  logic [15:0] x_addr_q, y_addr_q;
  logic x_acc_q, y_acc_q;
  logic [31:0] m_addr_q;
  logic m_acc_q, m_long_q;
  logic x_wbv_q, y_wbv_q, s_wbv_q;
  logic [3:0] x_wbr_q, y_wbr_q, s_wbr_q;
  logic [31:0] x_wbd_q, y_wbd_q, s_wbd_q;
  logic x_wrap_q, y_wrap_q, odd_q;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Raw register file read by number
  function automatic logic [31:0] file_read(input logic [3:0] num,
      input logic [31:0] r2, input logic [31:0] r3,
      input logic [31:0] r4, input logic [31:0] r5,
      input logic [31:0] r6, input logic [31:0] r7);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (num)
      agu_pkg::reg_r2: v = r2;
      agu_pkg::reg_r3: v = r3;
      agu_pkg::reg_r4: v = r4;
      agu_pkg::reg_r5: v = r5;
      agu_pkg::reg_r6: v = r6;
      agu_pkg::reg_r7: v = r7;
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction : file_read

  // Write back of the previous move is not in the file yet
  function automatic logic [31:0] forward(input logic [3:0] num,
      input logic [31:0] raw);
    logic [31:0] v;
    v = raw;
    if (x_wbv_q && x_wbr_q == num) begin
      v = x_wbd_q;
    end
    if (y_wbv_q && y_wbr_q == num) begin
      v = y_wbd_q;
    end
    if (s_wbv_q && s_wbr_q == num) begin
      v = s_wbd_q;
    end
    return v;
  endfunction : forward

  // X/Y bus address from a pointer
  function automatic logic [15:0] xy_bus(input logic [31:0] p);
    return {p[15:1], 1'b0};
  endfunction : xy_bus

  // ----------------------------------------------------------------
  // Request decode
  // ----------------------------------------------------------------
  wire logic dual_req;
  wire logic single_req;
  wire logic [3:0] x_num;
  wire logic [3:0] y_num;
  wire logic [3:0] s_num;

  assign dual_req = x_word_move || y_word_move;
  // Dual transfer owns the cycle; a clashing single request is dropped
  assign single_req = single_move && !dual_req;
  assign x_num = x_pointer_sel ? agu_pkg::reg_r5 : agu_pkg::reg_r4;
  assign y_num = y_pointer_sel ? agu_pkg::reg_r7 : agu_pkg::reg_r6;
  assign s_num = 4'(agu_pkg::reg_r2 + {2'b00, single_pointer_sel});

  // ----------------------------------------------------------------
  // Operand fetch with forwarding
  // ----------------------------------------------------------------
  logic [31:0] x_ptr;
  logic [31:0] y_ptr;
  logic [31:0] s_ptr;
  logic [31:0] x_idx;
  logic [31:0] y_idx;

  // Process form so the write back flops read inside forward wake it
  always_comb begin
    x_ptr = forward(x_num,
        file_read(x_num, reg_r2, reg_r3, reg_r4, reg_r5, reg_r6, reg_r7));
    y_ptr = forward(y_num,
        file_read(y_num, reg_r2, reg_r3, reg_r4, reg_r5, reg_r6, reg_r7));
    s_ptr = forward(s_num,
        file_read(s_num, reg_r2, reg_r3, reg_r4, reg_r5, reg_r6, reg_r7));
    x_idx = forward(agu_pkg::reg_r8, reg_r8);
    y_idx = forward(agu_pkg::reg_r9, reg_r9);
  end

  // ----------------------------------------------------------------
  // Circular bounds
  // ----------------------------------------------------------------
  wire logic [15:0] start_field;
  wire logic [15:0] end_field;
  wire logic x_circ;
  wire logic y_circ;

  assign start_field = bounds_q[start_field_lsb +: field_w];
  assign end_field = bounds_q[end_field_lsb +: field_w];
  // Only one pointer may wrap; Y takes precedence
  assign x_circ = x_circular_enable && !y_circular_enable;
  assign y_circ = y_circular_enable;
  assign bounds_d = bounds_load ? bounds_value : bounds_q;

  // ----------------------------------------------------------------
  // Dual pointer updates
  // ----------------------------------------------------------------
  wire logic [31:0] x_next;
  wire logic [31:0] y_next;
  wire logic x_wrap;
  wire logic y_wrap;

  xy_pointer_update u_x_update (
    .pointer(x_ptr),
    .mode(x_mode),
    .index(x_idx[15:0]),
    .circular(x_circ),
    .start_field(start_field),
    .end_field(end_field),
    .updated(x_next),
    .wrapped(x_wrap)
  );

  xy_pointer_update u_y_update (
    .pointer(y_ptr),
    .mode(y_mode),
    .index(y_idx[15:0]),
    .circular(y_circ),
    .start_field(start_field),
    .end_field(end_field),
    .updated(y_next),
    .wrapped(y_wrap)
  );

  // ----------------------------------------------------------------
  // Single pointer update, always linear over 32 bits
  // ----------------------------------------------------------------
  wire logic [31:0] s_step;
  wire logic [31:0] s_next;
  wire logic [31:0] s_addr;

  assign s_step = single_long_move ? single_step_long : single_step_word;
  assign s_next = (single_mode == s_index) ? 32'(s_ptr + x_idx) :
                  (single_mode == s_inc) ? 32'(s_ptr + s_step) :
                  (single_mode == s_dec) ? 32'(s_ptr - s_step) :
                  s_ptr;
  // Pre-decrement drives the new value, the rest the old one
  assign s_addr = (single_mode == s_dec) ? s_next : s_ptr;

  // ----------------------------------------------------------------
  // Operand alignment watch
  // ----------------------------------------------------------------
  wire logic odd_d;

  // Bit 0 is a software duty; flagged here, never corrected
  assign odd_d = (x_word_move && (x_ptr[0] || (x_mode == xy_index &&
                  x_idx[0]))) ||
                 (y_word_move && (y_ptr[0] || (y_mode == xy_index &&
                  y_idx[0]))) ||
                 ((x_circ || y_circ) && dual_req &&
                  (start_field[0] || end_field[0]));

  // ----------------------------------------------------------------
  // Execute stage registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!rstn) begin
      bounds_q <= bounds_reset;
    end else begin
      bounds_q <= bounds_d;
    end
  end

  // X and Y addresses latch on the same edge
  always_ff @(posedge clk) begin
    if (!rstn) begin
      x_addr_q <= 16'h0000;
      y_addr_q <= 16'h0000;
      x_acc_q <= 1'b0;
      y_acc_q <= 1'b0;
    end else begin
      x_addr_q <= x_word_move ? xy_bus(x_ptr) : x_addr_q;
      y_addr_q <= y_word_move ? xy_bus(y_ptr) : y_addr_q;
      x_acc_q <= x_word_move;
      y_acc_q <= y_word_move;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      m_addr_q <= 32'h0000_0000;
      m_acc_q <= 1'b0;
      m_long_q <= 1'b0;
    end else begin
      m_addr_q <= single_req ? s_addr : m_addr_q;
      m_acc_q <= single_req;
      m_long_q <= single_req ? single_long_move : m_long_q;
    end
  end

  // Keep mode still writes back, with the value unchanged
  always_ff @(posedge clk) begin
    if (!rstn) begin
      x_wbv_q <= 1'b0;
      y_wbv_q <= 1'b0;
      x_wbr_q <= 4'h0;
      y_wbr_q <= 4'h0;
      x_wbd_q <= 32'h0000_0000;
      y_wbd_q <= 32'h0000_0000;
    end else begin
      x_wbv_q <= x_word_move;
      y_wbv_q <= y_word_move;
      x_wbr_q <= x_word_move ? x_num : x_wbr_q;
      y_wbr_q <= y_word_move ? y_num : y_wbr_q;
      x_wbd_q <= x_word_move ? x_next : x_wbd_q;
      y_wbd_q <= y_word_move ? y_next : y_wbd_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      s_wbv_q <= 1'b0;
      s_wbr_q <= 4'h0;
      s_wbd_q <= 32'h0000_0000;
    end else begin
      s_wbv_q <= single_req;
      s_wbr_q <= single_req ? s_num : s_wbr_q;
      s_wbd_q <= single_req ? s_next : s_wbd_q;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      x_wrap_q <= 1'b0;
      y_wrap_q <= 1'b0;
      odd_q <= 1'b0;
    end else begin
      x_wrap_q <= x_word_move && x_wrap;
      y_wrap_q <= y_word_move && y_wrap;
      odd_q <= odd_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign x_address_bus = x_addr_q;
  assign x_access = x_acc_q;
  assign y_address_bus = y_addr_q;
  assign y_access = y_acc_q;
  assign main_address_bus = m_addr_q;
  assign main_access = m_acc_q;
  assign main_long = m_long_q;
  assign x_wb_valid = x_wbv_q;
  assign x_wb_reg = x_wbr_q;
  assign x_wb_value = x_wbd_q;
  assign y_wb_valid = y_wbv_q;
  assign y_wb_reg = y_wbr_q;
  assign y_wb_value = y_wbd_q;
  assign s_wb_valid = s_wbv_q;
  assign s_wb_reg = s_wbr_q;
  assign s_wb_value = s_wbd_q;
  assign circular_bounds_register = bounds_q;
  assign x_wrapped = x_wrap_q;
  assign y_wrapped = y_wrap_q;
  assign odd_operand = odd_q;

endmodule : dsp_data_address_generator

/* testbench/agu_properties.sv */
module agu_properties
  import agu_pkg::*;
(
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Inputs watched
  input wire logic [31:0] reg_r4,
  input wire logic [31:0] reg_r5,
  input wire logic [31:0] reg_r6,
  input wire logic [31:0] reg_r7,
  input wire logic y_circular_enable,
  input wire logic bounds_load,
  input wire logic [31:0] bounds_value,
  input wire logic x_word_move,
  input wire logic x_pointer_sel,
  input wire xy_mode_t x_mode,
  input wire logic y_word_move,
  input wire logic y_pointer_sel,
  input wire xy_mode_t y_mode,
  input wire logic single_move,
  input wire single_mode_t single_mode,
  // Outputs watched
  input wire logic [15:0] x_address_bus,
  input wire logic x_access,
  input wire logic y_access,
  input wire logic [31:0] main_address_bus,
  input wire logic main_access,
  input wire logic main_long,
  input wire logic x_wb_valid,
  input wire logic [31:0] x_wb_value,
  input wire logic y_wb_valid,
  input wire logic s_wb_valid,
  input wire logic [31:0] s_wb_value,
  input wire logic [31:0] circular_bounds_register,
  input wire logic x_wrapped,
  input wire logic y_wrapped
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Forwarded write back hides the file value, so skip those cycles
  logic [31:0] xp_q;
  logic fresh_x;
  logic y_hit;
  logic solo;
  assign fresh_x = x_word_move && !x_wb_valid && !s_wb_valid;
  assign y_hit = y_circular_enable && y_mode != xy_keep &&
    (y_pointer_sel ? reg_r7[15:1] : reg_r6[15:1]) ==
    circular_bounds_register[31:17];
  assign solo = single_move && !x_word_move && !y_word_move;
  always_ff @(posedge clk) begin
    xp_q <= x_pointer_sel ? reg_r5 : reg_r4;
  end
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  a_x_strobe: assert property (x_word_move |=> x_access && x_wb_valid)
    else $error("x access missing");
  a_y_strobe: assert property (y_word_move |=> y_access && y_wb_valid)
    else $error("y access missing");
  a_x_addr_old: assert property (fresh_x |=>
    x_address_bus == {xp_q[15:1], 1'b0}) else $error("x address wrong");
  a_x_upper_kept: assert property (fresh_x |=>
    x_wb_value[31:16] == xp_q[31:16]) else $error("x upper half moved");
  a_keep_no_wrap: assert property (fresh_x && x_mode == xy_keep |=>
    !x_wrapped && x_wb_value == xp_q) else $error("keep mode changed x");
  a_x_yields_y: assert property (x_word_move && y_circular_enable |=>
    !x_wrapped) else $error("x wrapped with y enable");
  a_y_wrap_match: assert property (y_word_move && !y_wb_valid |=>
    y_wrapped == $past(y_hit)) else $error("y wrap decision wrong");
  a_dec_first: assert property (solo && single_mode == s_dec |=>
    main_access && main_address_bus == s_wb_value)
    else $error("pre decrement address wrong");
  a_inc_after: assert property (solo && single_mode == s_inc |=>
    main_address_bus + (main_long ? 32'h4 : 32'h2) == s_wb_value)
    else $error("post increment step wrong");
  a_bounds_whole: assert property (bounds_load |=>
    circular_bounds_register == $past(bounds_value))
    else $error("bounds load wrong");
endmodule : agu_properties

bind dsp_data_address_generator agu_properties props (.*);

/* testbench/reg_file_model.sv */
module reg_file_model (
  // Clock
  input wire logic clk,
  // Bench load
  input wire logic ld_en,
  input wire logic [3:0] ld_num,
  input wire logic [31:0] ld_val,
  // Write back
  input wire logic x_wb_valid,
  input wire logic [3:0] x_wb_reg,
  input wire logic [31:0] x_wb_value,
  input wire logic y_wb_valid,
  input wire logic [3:0] y_wb_reg,
  input wire logic [31:0] y_wb_value,
  input wire logic s_wb_valid,
  input wire logic [3:0] s_wb_reg,
  input wire logic [31:0] s_wb_value,
  // Read values
  output logic [31:0] reg_r2,
  output logic [31:0] reg_r3,
  output logic [31:0] reg_r4,
  output logic [31:0] reg_r5,
  output logic [31:0] reg_r6,
  output logic [31:0] reg_r7,
  output logic [31:0] reg_r8,
  output logic [31:0] reg_r9
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [31:0] rf_q [16];
  // Loads only come while the generator is idle, so no clash
  always_ff @(posedge clk) begin
    if (ld_en) rf_q[ld_num] <= ld_val;
    if (x_wb_valid) rf_q[x_wb_reg] <= x_wb_value;
    if (y_wb_valid) rf_q[y_wb_reg] <= y_wb_value;
    if (s_wb_valid) rf_q[s_wb_reg] <= s_wb_value;
  end
  assign reg_r2 = rf_q[2];
  assign reg_r3 = rf_q[3];
  assign reg_r4 = rf_q[4];
  assign reg_r5 = rf_q[5];
  assign reg_r6 = rf_q[6];
  assign reg_r7 = rf_q[7];
  assign reg_r8 = rf_q[8];
  assign reg_r9 = rf_q[9];
endmodule : reg_file_model

/* testbench/testbench.sv */
module testbench
  import agu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rstn, x_circular_enable, y_circular_enable, bounds_load;
  logic x_word_move, x_pointer_sel, y_word_move, y_pointer_sel, ld_en;
  logic single_move, single_long_move, odd_operand;
  logic [1:0] single_pointer_sel;
  logic [3:0] ld_num, x_wb_reg, y_wb_reg, s_wb_reg;
  logic [31:0] bounds_value, ld_val, circular_bounds_register;
  logic [31:0] reg_r2, reg_r3, reg_r4, reg_r5, reg_r6, reg_r7, reg_r8;
  logic [31:0] reg_r9, main_address_bus, x_wb_value, y_wb_value, s_wb_value;
  xy_mode_t x_mode, y_mode;
  single_mode_t single_mode;
  logic [15:0] x_address_bus, y_address_bus;
  logic x_access, y_access, main_access, main_long, x_wb_valid, y_wb_valid;
  logic s_wb_valid, x_wrapped, y_wrapped;
  int n_mismatch, compares, cyc;
  logic [31:0] sh [16];
  logic [31:0] sh_b;
  logic [52:0] xq [$], yq [$];
  logic [69:0] sq [$];

  dsp_data_address_generator dut (.*);
  reg_file_model far (.*);

  always #2.5 clk = ~clk;
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task check(input logic [69:0] seen, input logic [69:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task wrap_up;
    if (n_mismatch == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up

  function logic [36:0] xy_next(input logic [31:0] p, input xy_mode_t m,
                                input logic [15:0] ix, input logic c,
                                input logic [3:0] r);
    logic [15:0] s;
    s = (m == xy_inc) ? 16'h0002 : (m == xy_index) ? ix : 16'h0000;
    if (c && m != xy_keep && p[15:1] == sh_b[31:17])
      return {1'b1, r, p[31:16], sh_b[15:1], p[0]};
    return {1'b0, r, p[31:16], p[15:0] + s};
  endfunction : xy_next

  // Expectations follow the inputs just driven; shadow file updated too
  task predict;
    logic [36:0] e;
    logic [31:0] p, n, st;
    logic [3:0] r;
    if (x_word_move) begin
      r = x_pointer_sel ? 4'h5 : 4'h4;
      e = xy_next(sh[r], x_mode, sh[8][15:0],
                  x_circular_enable && !y_circular_enable, r);
      xq.push_back({e[36], sh[r][15:1], 1'b0, e[35:0]});
      sh[r] = e[31:0];
    end
    if (y_word_move) begin
      r = y_pointer_sel ? 4'h7 : 4'h6;
      e = xy_next(sh[r], y_mode, sh[9][15:0], y_circular_enable, r);
      yq.push_back({e[36], sh[r][15:1], 1'b0, e[35:0]});
      sh[r] = e[31:0];
    end
    if (single_move && !x_word_move && !y_word_move) begin
      r = {2'b00, single_pointer_sel} + 4'h2;
      p = sh[r];
      st = single_long_move ? 32'h4 : 32'h2;
      case (single_mode)
        s_keep: n = p;
        s_index: n = p + sh[8];
        s_inc: n = p + st;
        default: n = p - st;
      endcase
      sq.push_back({single_long_move, (single_mode == s_dec) ? n : p,
                    r, n, 1'b1});
      sh[r] = n;
    end
    if (bounds_load) sh_b = bounds_value;
  endtask : predict

  // ----------------------------------------------------------------
  // Result watcher
  // ----------------------------------------------------------------
  always @(posedge clk) begin
    #1;
    if (x_access) check({16'h0, x_wb_valid, x_wrapped, x_address_bus,
      x_wb_reg, x_wb_value}, {17'h1, xq.size() ? xq.pop_front() : 'x});
    if (y_access) check({16'h0, y_wb_valid, y_wrapped, y_address_bus,
      y_wb_reg, y_wb_value}, {17'h1, yq.size() ? yq.pop_front() : 'x});
    if (main_access) check({main_long, main_address_bus, s_wb_reg,
      s_wb_value, s_wb_valid}, sq.size() ? sq.pop_front() : 'x);
    if (rstn && bounds_load) check({38'h0, circular_bounds_register},
      {38'h0, bounds_value});
    if (rstn) check(70'(odd_operand), 70'h0);
  end

  // A hang stops here long after the short sequence should end
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 2000) begin
      n_mismatch++;
      wrap_up;
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {clk, rstn, ld_en, ld_num, ld_val, bounds_load, bounds_value} = '0;
    {x_word_move, x_pointer_sel, y_word_move, y_pointer_sel} = '0;
    {single_move, single_long_move, single_pointer_sel} = '0;
    {x_circular_enable, y_circular_enable} = '0;
    x_mode = xy_keep;
    y_mode = xy_keep;
    single_mode = s_keep;
    {n_mismatch, compares, cyc} = '0;
    sh_b = '0;
    void'($urandom(32'hf0c7ff3e));
    repeat (8) @(posedge clk);
    @(negedge clk);
    rstn = 1;
    for (int i = 2; i < 10; i++) begin
      @(negedge clk);
      ld_en = 1;
      ld_num = 4'(i);
      ld_val = (i > 7) ? ((i == 8) ? 32'hffff_fffe : 32'h4)
                       : {16'($urandom), 16'h7000};
      sh[i] = ld_val;
    end
    @(negedge clk);
    ld_en = 0;
    bounds_load = 1;
    bounds_value = 32'h7004_7000;
    predict;
    // Walk round the ring: 7000, 7002, 7004 then back to the start
    repeat (5) begin
      @(negedge clk);
      bounds_load = 0;
      {x_word_move, x_pointer_sel} = 2'b10;
      x_mode = xy_inc;
      {x_circular_enable, y_circular_enable} = 2'b10;
      predict;
    end
    repeat (300) begin
      @(negedge clk);
      {x_word_move, y_word_move, single_move} = 3'($urandom);
      {x_pointer_sel, y_pointer_sel, single_long_move} = 3'($urandom);
      {x_circular_enable, y_circular_enable} = 2'($urandom);
      x_mode = xy_mode_t'($urandom % 3);
      y_mode = xy_mode_t'($urandom % 3);
      single_pointer_sel = 2'($urandom);
      single_mode = single_mode_t'(2'($urandom));
      bounds_load = ($urandom % 8) == 0;
      bounds_value = {11'h380, 4'($urandom), 1'b0, 16'h7000};
      predict;
    end
    @(negedge clk);
    {x_word_move, y_word_move, single_move, bounds_load} = '0;
    repeat (4) @(negedge clk);
    check(70'(xq.size() + yq.size() + sq.size()), 70'h0);
    wrap_up;
  end
endmodule : testbench
